// file: src/sef_pkg.sv
// Purpose: Shared constants and types of the serial EEPROM front end
// Assumes: One system clock samples every serial pin
// Notes:   Status layout keeps the protect enable in the top bit
package sef_pkg;

  // Status register layout and reset value
  localparam int unsigned    SR_PEN_BIT  = 7;
  localparam int unsigned    SR_BP_LO    = 2;
  localparam int unsigned    SR_WEL_BIT  = 1;
  localparam logic [7:0]     SR_RESET    = 8'h00;
  localparam logic [7:0]     SR_WR_MASK  = 8'h8c;  // Writable: pen, bp1, bp0

  // Framing constants
  localparam logic [2:0]     LAST_BIT    = 3'h7;
  localparam logic [3:0]     OP_HI_NIB   = 4'h0;

  // Opcode low three bits (bit 3 is a don't-care)
  localparam logic [2:0]     OP_WEN_SET  = 3'h6;
  localparam logic [2:0]     OP_WEN_CLR  = 3'h4;
  localparam logic [2:0]     OP_SR_READ  = 3'h5;
  localparam logic [2:0]     OP_SR_WRITE = 3'h1;
  localparam logic [2:0]     OP_ARR_READ = 3'h3;
  localparam logic [2:0]     OP_ARR_WR   = 3'h2;

  // Serial command state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC  = 2'b01,
    ST_DATA = 2'b10,
    ST_DEAD = 2'b11
  } sef_state_t;

  // Pins driven by the bus master
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } sef_pins_t;

  // Serial output pin with its enable
  typedef struct packed {
    logic data;
    logic oe;
  } sef_so_t;

endpackage

// file: src/sef_front_end.sv
// Purpose: Slave-only serial front end of a serial EEPROM
// Assumes: Master uses clock mode 0; mclk far faster than the serial clock
// Notes:   Array storage lives outside; bytes cross on the user side
`timescale 1ns/10ps
module sef_front_end (
  // Clock, reset, enable
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               ce,
  // Serial pins to and from the master
  input  wire sef_pkg::sef_pins_t pins,
  output sef_pkg::sef_so_t        so_q,
  // User side toward the array
  input  wire logic [7:0]         tx_data,
  output logic [7:0]              opcode_q,
  output logic [7:0]              rx_byte_q,
  output logic                    rx_valid_q,
  output logic [7:0]              status_q
);

  // Two-stage synchronisers plus one history stage for edges
  sef_pkg::sef_pins_t s1_q, s2_q, s3_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      s2_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      s3_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end else if (ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  sef_pkg::sef_state_t state_q, state_d;
  logic [2:0] cnt_q;
  logic [7:0] rxsh_q;
  logic [7:0] txsh_q;
  logic       wrsr_pend_q;
  logic       wp_abort_q;

  // Edge and qualifier decode; the sck is only sampled, never driven
  wire sel       = !s2_q.cs_n;
  wire cs_fall   = s3_q.cs_n && !s2_q.cs_n;
  wire cs_rise   = !s3_q.cs_n && s2_q.cs_n;
  wire paused    = !s2_q.hold_n;
  wire sck_rise  = !s3_q.sck && s2_q.sck;
  wire sck_fall  = s3_q.sck && !s2_q.sck;
  wire active    = sel && !paused;
  wire shift_in  = active && sck_rise &&
                   (state_q == sef_pkg::ST_OPC || state_q == sef_pkg::ST_DATA);
  wire byte_done = shift_in && (cnt_q == sef_pkg::LAST_BIT);
  wire [7:0] rx_next = {rxsh_q[6:0], s2_q.si};

  // Opcode decode of the byte that just completed and of the captured opcode
  wire [2:0] op_lo   = rx_next[2:0];
  wire op_valid = (rx_next[7:4] == sef_pkg::OP_HI_NIB) &&
                  (op_lo == sef_pkg::OP_WEN_SET || op_lo == sef_pkg::OP_WEN_CLR
                || op_lo == sef_pkg::OP_SR_READ || op_lo == sef_pkg::OP_SR_WRITE
                || op_lo == sef_pkg::OP_ARR_READ || op_lo == sef_pkg::OP_ARR_WR);
  wire cur_sr_rd  = opcode_q[2:0] == sef_pkg::OP_SR_READ;
  wire cur_arr_rd = opcode_q[2:0] == sef_pkg::OP_ARR_READ;
  wire cur_sr_wr  = opcode_q[2:0] == sef_pkg::OP_SR_WRITE;
  wire reading    = state_q == sef_pkg::ST_DATA && (cur_sr_rd || cur_arr_rd);

  // Hardware protection: pin low and enable set; enable 0 masks the pin
  wire hw_prot = status_q[sef_pkg::SR_PEN_BIT] && !s2_q.wp_n;
  wire sr_wr   = cs_rise && wrsr_pend_q && !wp_abort_q && !hw_prot &&
                 status_q[sef_pkg::SR_WEL_BIT];
  wire [7:0] sr_new = (rxsh_q & sef_pkg::SR_WR_MASK) |
                      (status_q & ~sef_pkg::SR_WR_MASK);

  // Next command state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sef_pkg::ST_IDLE: state_d = state_q;
      sef_pkg::ST_OPC:
        if (byte_done)
          state_d = op_valid ? sef_pkg::ST_DATA : sef_pkg::ST_DEAD;
      sef_pkg::ST_DATA: state_d = state_q;
      sef_pkg::ST_DEAD: state_d = state_q;
    endcase
    if (!sel)
      state_d = sef_pkg::ST_IDLE;
    if (cs_fall)
      state_d = sef_pkg::ST_OPC;
  end

  // Command state, bit counter and input shifter; all hold while paused
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= sef_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
      rxsh_q  <= 8'h00;
    end else if (ce) begin
      state_q <= state_d;
      if (cs_fall)
        cnt_q <= 3'h0;
      else if (shift_in) begin
        cnt_q  <= cnt_q + 3'h1;
        rxsh_q <= rx_next;
      end
    end
  end

  // Opcode capture, received data strobe, write latch and status writes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      opcode_q    <= 8'h00;
      rx_byte_q   <= 8'h00;
      rx_valid_q  <= 1'b0;
      status_q    <= sef_pkg::SR_RESET;
      wrsr_pend_q <= 1'b0;
      wp_abort_q  <= 1'b0;
    end else if (ce) begin
      rx_valid_q <= byte_done && state_q == sef_pkg::ST_DATA;
      if (byte_done && state_q == sef_pkg::ST_DATA)
        rx_byte_q <= rx_next;
      if (byte_done && state_q == sef_pkg::ST_OPC && op_valid) begin
        opcode_q <= rx_next;
        if (op_lo == sef_pkg::OP_WEN_SET)
          status_q[sef_pkg::SR_WEL_BIT] <= 1'b1;
        if (op_lo == sef_pkg::OP_WEN_CLR)
          status_q[sef_pkg::SR_WEL_BIT] <= 1'b0;
      end
      // Pending flag sets on the first data byte of a status write; the last byte shifted in is written
      if (cs_fall)
        wrsr_pend_q <= 1'b0;
      else if (byte_done && state_q == sef_pkg::ST_DATA && cur_sr_wr
               && !wrsr_pend_q)
        wrsr_pend_q <= 1'b1;
      // Pin falling while selected in a status write with the protect enable set aborts it
      if (cs_fall)
        wp_abort_q <= 1'b0;
      else if (sel && cur_sr_wr && state_q == sef_pkg::ST_DATA &&
               s3_q.wp_n && !s2_q.wp_n &&
               status_q[sef_pkg::SR_PEN_BIT])
        wp_abort_q <= 1'b1;
      // Commit happens on deselect; a write drops the write latch
      if (sr_wr) begin
        status_q                      <= sr_new;
        status_q[sef_pkg::SR_WEL_BIT] <= 1'b0;
      end
    end
  end

  // Output shifter: load at byte end, present next bit on falling clock
  wire [7:0] tx_src  = cur_sr_rd ? status_q : tx_data;
  wire       so_en_d = sel && !paused && reading;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      txsh_q <= 8'h00;
      so_q   <= '{data: 1'b0, oe: 1'b0};
    end else if (ce) begin
      so_q.oe <= so_en_d;
      if (byte_done)
        txsh_q <= (state_q == sef_pkg::ST_OPC) ?
                  ((op_lo == sef_pkg::OP_SR_READ) ? status_q : 8'h00) : tx_src;
      else if (active && sck_fall && reading) begin
        so_q.data <= txsh_q[7];
        txsh_q    <= {txsh_q[6:0], 1'b0};
      end
    end
  end

  // Checks
  deselect_tri_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && !sel) |=> !so_q.oe) else $error("output driven while deselected");
  pause_tri_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && paused) |=> !so_q.oe) else $error("output driven while paused");
  cs_restart_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cs_fall) |=> (state_q == sef_pkg::ST_OPC && cnt_q == 3'h0))
    else $error("select fall did not restart sequence");
  bad_opcode_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && byte_done && state_q == sef_pkg::ST_OPC && !op_valid && sel)
    |=> state_q == sef_pkg::ST_DEAD) else $error("invalid opcode accepted");
  dead_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == sef_pkg::ST_DEAD) |=> (!so_q.oe && $stable(rx_byte_q)))
    else $error("activity after invalid opcode");
  hold_freeze_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && sel && paused && !cs_fall) |=> ($stable(cnt_q) && $stable(rxsh_q)))
    else $error("pause did not freeze sequence");
  protect_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cs_rise && hw_prot) |=> $stable(status_q))
    else $error("status written while protected");
  msb_out_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && active && sck_fall && reading && !byte_done)
    |=> so_q.data == $past(txsh_q[7])) else $error("output bit order wrong");
  byte_strobe_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && byte_done && state_q == sef_pkg::ST_DATA)
    |=> (rx_valid_q && rx_byte_q == $past(rx_next)))
    else $error("data byte not delivered");

endmodule // sef_front_end

// file: sim/sef_spi_master.sv
// Purpose: Bus master model driving the serial EEPROM pins
// Assumes: Clock mode 0, serial clock period 125 ns
// Notes:   A released SO line is read back as unknown
`timescale 1ns/10ps
module sef_spi_master (
  // System clock, only used to keep pin changes off its edges
  input  wire logic             mclk,
  // Pins toward the device
  output sef_pkg::sef_pins_t pins,
  // Serial output from the device
  input  wire sef_pkg::sef_so_t so
);
  // Half period of the serial clock
  localparam realtime HP = 62.5;

  // Idle bus: deselected, clock low, pause and protect released
  initial pins = 5'b10011;

  // Select edge; every sequence opens with a falling select
  // A 1.25 ns offset keeps every later half-period step off mclk edges
  task automatic sel(input logic cs);
    @(posedge mclk);
    #1.25;
    #HP pins.cs_n = cs;
    #HP;
  endtask

  // Write protect level, changed between or inside frames
  task automatic set_wp(input logic v);
    pins.wp_n = v;
  endtask

  // Pause with the clock low; clock and data keep moving meanwhile
  task automatic pause();
    pins.hold_n = 1'b0;
    repeat (3) begin
      #HP pins.sck = 1'b1;
      pins.si = ~pins.si;
      #HP pins.sck = 1'b0;
    end
    #HP pins.hold_n = 1'b1;
    #HP;
  endtask

  // One byte, MSB first; this model alone makes the serial clock
  task automatic xfer(input logic [7:0] tx, input int pz,
                      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (i == pz)
        pause();
      pins.si = tx[i];
      #HP pins.sck = 1'b1;
      rx[i] = so.oe ? so.data : 1'bx;
      #HP pins.sck = 1'b0;
    end
    // Stale data would hide a late sample, so flip it
    pins.si = ~pins.si;
  endtask
endmodule  // sef_spi_master

// file: sim/testbench.sv
// Purpose: Self-checking bench for the serial EEPROM front end
// Assumes: Driver queues expected bytes, a monitor compares them
// Notes:   Random bytes come from an LFSR with a fixed seed
`timescale 1ns/10ps
module testbench;
  logic               mclk        = 1'b0;
  logic               nrst        = 1'b0;
  logic [7:0]         tx_data     = 8'h00;
  logic               ce          = 1'b1;
  logic [31:0]        rnd         = 32'h48b9;
  int                 num_errors  = 0;
  int                 checks_done = 0;
  int                 cyc         = 0;
  logic [7:0]         exp_q[$];
  logic [7:0]         sr          = 8'h00;
  logic [7:0]         rd;
  logic [7:0]         bad[4]      = '{8'h00, 8'h07, 8'hf2, 8'h1b};
  sef_pkg::sef_pins_t pins;
  sef_pkg::sef_so_t   so;
  logic [7:0]         opcode;
  logic [7:0]         rx_byte;
  logic [7:0]         status;
  logic               rx_valid;

  // 125 MHz system clock
  always #4 mclk = ~mclk;

  sef_spi_master m (.mclk(mclk), .pins(pins), .so(so));
  sef_front_end uut (.mclk(mclk), .nrst(nrst), .ce(ce), .pins(pins),
    .so_q(so), .tx_data(tx_data), .opcode_q(opcode), .rx_byte_q(rx_byte),
    .rx_valid_q(rx_valid), .status_q(status));

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    chk("exp_left", 8'h00, 8'(exp_q.size()));
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One framed command; every byte after a valid opcode is received,
  // reads included, so each one is noted for the monitor
  task automatic frame(logic [7:0] op, logic [7:0] d, int pz, logic wpf,
                       int nb = 1);
    logic [7:0] r;
    m.sel(1'b0);
    m.xfer(op, -1, r);
    if (op[7:4] == 4'h0 && op[2:0] != 3'h6 && op[2:0] != 3'h4 &&
        op[2:0] != 3'h0 && op[2:0] != 3'h7)
      repeat (nb) exp_q.push_back(d);
    if (op[2:0] != 3'h6 && op[2:0] != 3'h4)
      repeat (nb) m.xfer(d, pz, rd);
    // Short low pulse: only the abort, not the level at commit, can block
    if (wpf) begin
      m.set_wp(1'b0);
      #62.5;
      m.set_wp(1'b1);
    end
    m.sel(1'b1);
  endtask

  // Enable writes, then write status; only writable bits compared
  task automatic wr_sr(logic [7:0] d, logic ok, logic wpf);
    frame(8'h06, 8'h00, -1, 1'b0);
    frame(8'h01, d, -1, wpf);
    if (ok)
      sr = d & sef_pkg::SR_WR_MASK;
    chk("status", sr, status & sef_pkg::SR_WR_MASK);
  endtask

  // Timeout, and each received-byte pulse takes the oldest note
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
    if (nrst && rx_valid === 1'b1)
      chk("rx", exp_q.size() ? exp_q.pop_front() : 8'hxx, rx_byte);
  end

  initial begin
    repeat (8) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge mclk);
    chk("status_rst", sef_pkg::SR_RESET, status);
    frame(8'h05, 8'h00, -1, 1'b0);
    chk("rdsr", 8'h00, rd);
    frame(8'h0e, 8'h00, -1, 1'b0);
    frame(8'h05, 8'h00, -1, 1'b0);
    chk("rdsr_wel", 8'h02, rd);
    frame(8'h04, 8'h00, -1, 1'b0);
    frame(8'h05, 8'h00, -1, 1'b0);
    chk("rdsr_wrdi", 8'h00, rd);
    wr_sr(8'h8c, 1'b1, 1'b0);
    m.set_wp(1'b0);
    wr_sr(8'h00, 1'b0, 1'b0);
    m.set_wp(1'b1);
    wr_sr(8'h04, 1'b0, 1'b1);
    m.set_wp(1'b1);
    wr_sr(8'h04, 1'b1, 1'b0);
    m.set_wp(1'b0);
    wr_sr(8'h08, 1'b1, 1'b0);
    m.set_wp(1'b1);
    foreach (bad[i]) begin
      frame(bad[i], 8'h05, -1, 1'b0);
      chk("so_dead", 8'hxx, rd);
      chk("opcode_kept", 8'h01, opcode);
    end
    frame(8'h05, 8'h00, -1, 1'b0);
    chk("rdsr_again", sr, rd);
    // Enable low through a whole write-enable frame must leave no trace
    @(posedge mclk);
    #1 ce = 1'b0;
    frame(8'h06, 8'h00, -1, 1'b0);
    @(posedge mclk);
    #1 ce = 1'b1;
    frame(8'h05, 8'h00, -1, 1'b0);
    chk("ce_freeze", sr, rd);
    repeat (4) begin
      rnd = lfsr(rnd);
      @(posedge mclk);
      #1 tx_data = rnd[15:8];
      frame(8'h02, rnd[7:0], 3, 1'b0);
      // First read byte is a filler; the user byte follows it
      frame(8'h03, 8'h00, -1, 1'b0, 2);
      chk("read", rnd[15:8], rd);
      chk("opcode", 8'h03, opcode);
    end
    stop_test();
  end
endmodule  // testbench
